/* File: rtl/pci_isa_consts.svh */
`ifndef PCI_ISA_CONSTS_SVH
`define PCI_ISA_CONSTS_SVH

// Configuration space offsets and reset values
`define OFF_ISA_CTL      8'h40
`define OFF_POST_CTL     8'h46
`define ISA_CTL_RST      8'h00
`define POST_CTL_RST     8'h00

// Field positions
`define BIT_CMD_FALL_DLY 7
`define BIT_CMD_RISE_DLY 5
`define BIT_ROM_WS       1
`define BIT_POST_EN      0

// PCI timing, in PCI clocks
`define LAT_INIT_CLKS    5'd16
`define CFG_DEVSEL_CLKS  5'd2
`define CFG_TRDY_CLKS    5'd4
`define CFG_WR_IRDY_CLKS 5'd2
`define SUB_DEVSEL_CLKS  5'd3

// ISA wait states, in BCLKs
`define WS_8BIT          5'd4
`define WS_16BIT         5'd0
`define WS_ROM_DEF       5'd3

// PCI commands
`define CMD_MRD          4'h6
`define CMD_MWR          4'h7
`define CMD_CFGRD        4'ha
`define CMD_CFGWR        4'hb
`define CMD_MRM          4'hc
`define CMD_MRL          4'he
`define CMD_MWI          4'hf

`endif

/* File: rtl/pci_isa_pkg.sv */
package pci_isa_pkg;

	typedef enum logic [2:0] {P_IDLE, P_DEC, P_CFG, P_MEM, P_HOLD, P_TURN} pci_state_t;

	typedef enum logic [2:0] {I_IDLE, I_ADDR, I_DLY, I_CMD, I_REC} isa_state_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [3:0]  be;
		logic        write;
		logic [31:0] data;
		logic        rom;
	} isa_req_t;

endpackage : pci_isa_pkg

/* File: rtl/pci_isa_bridge.sv */
// Behaviour
// [R1] Claim unclaimed memory cycles outside own block by subtractive decode; forward to ISA.
// [R2] Finish first data phase within 16 clocks, burst phases within eight.
// [R3] During a burst, disconnect only when the next phase cannot meet latency.
// [R4] ISA reads and non-posted ISA writes run as delayed transactions.
// [R5] Initial phase too slow: start delayed transaction, answer with retry.
// [R6] Next burst phase too slow: disconnect with TRDY# and STOP# together.
// [R7] A retried master repeats the same request until it completes.
// [R8] Hold pending request, run ISA cycle, complete on identical repeat.
// [R9] Posting enabled: TRDY# one clock after FRAME# and IRDY#, then ISA write; here TRDY# comes one clock after DEVSEL#, four after FRAME#.
// [R10] New ISA access waits until a posted write finishes on ISA.
// [R11] SMEMR# and SMEMW# only for addresses in the first megabyte.
// [R12] Sample MEMCS16# at start of command state to choose 8 or 16 bits.
// [R13] Command at start of command state for 16-bit, middle for 8-bit.
// [R14] Control bit 7 delays command fall; bit 5 delays command rise.
// [R15] Extend the command while IOCHRDY is negated.
// [R16] Split wide requests into byte or word cycles; handle sparse byte enables.
// [R17] ROM reads assert MEMR# and SMEMR# at the falling edge of BALE.
// [R18] ROM cycles default to three wait states; bit 1 selects fewer.
// [R19] SA1, SA0, SBHE# follow byte enables and toggle across conversion cycles.
// [R20] Configuration select: DEVSEL# two clocks after FRAME#.
// [R21] Configuration read: data out, TRDY# at four clocks, release after IRDY#.
// [R22] Configuration write: TRDY# at later of four/IRDY#+2; latch one cycle earlier.
// [R23] Read multiple and read line act as read; write-invalidate as write.
// [R24] Only 32-bit addressing; dual address cycles get no response.
// [R25] Accept fast back-to-back cycles as a target.
`timescale 1ns/10ps
`include "pci_isa_consts.svh"

module pci_isa_bridge
	import pci_isa_pkg::*;
#(
	parameter logic [31:0] OWN_BASE    = 32'hffff0000,
	parameter logic [31:0] OWN_MASK    = 32'hffff0000,
	parameter logic [31:0] ROM_BASE    = 32'h000e0000,
	parameter logic [31:0] ROM_MASK    = 32'hfffe0000,
	parameter logic [4:0]  ROM_FAST_WS = 5'h01
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	// PCI
	input  wire logic        i_frame_n,
	input  wire logic        i_irdy_n,
	input  wire logic        i_idsel,
	input  wire logic        i_devsel_n,
	input  wire logic [31:0] i_ad,
	input  wire logic [3:0]  i_cbe_n,
	output logic      [31:0] o_ad,
	output logic             o_ad_oe,
	output logic             o_trdy_n,
	output logic             o_stop_n,
	output logic             o_devsel_n,
	output logic             o_ctl_oe,
	// ISA
	input  wire logic        i_bclk,
	input  wire logic        i_iochrdy,
	input  wire logic        i_memcs16_n,
	input  wire logic [15:0] i_sd,
	output logic      [23:0] o_sa,
	output logic             o_sbhe_n,
	output logic             o_bale,
	output logic             o_memr_n,
	output logic             o_memw_n,
	output logic             o_smemr_n,
	output logic             o_smemw_n,
	output logic      [15:0] o_sd,
	output logic             o_sd_oe
);

	function automatic logic [1:0] low_byte(input logic [3:0] m);
		low_byte = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
	endfunction : low_byte

	function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] lane);
		byte_of = w[{lane, 3'h0} +: 8];
	endfunction : byte_of

	// Command width in half-BCLK ticks, less one
	function automatic logic [4:0] cmd_ticks(input logic [4:0] ws, input logic rise_dly);
		cmd_ticks = {ws[3:0], 1'b1} + (rise_dly ? 5'h02 : 5'h00);
	endfunction : cmd_ticks

	// ISA pin synchronisers
	logic [1:0]  bclk_s;
	logic [1:0]  rdy_s;
	logic [1:0]  cs16_s;
	logic [15:0] sd_s0;
	logic [15:0] sd_s1;
	logic        bclk_d;

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			bclk_s <= 2'h0;
			rdy_s  <= 2'h3;
			cs16_s <= 2'h3;
			sd_s0  <= 16'h0000;
			sd_s1  <= 16'h0000;
			bclk_d <= 1'b0;
		end else begin
			bclk_s <= {bclk_s[0], i_bclk};
			rdy_s  <= {rdy_s[0], i_iochrdy};
			cs16_s <= {cs16_s[0], i_memcs16_n};
			sd_s0  <= i_sd;
			sd_s1  <= sd_s0;
			bclk_d <= bclk_s[1];
		end
	end

	// Shared state
	pci_state_t  pstate;
	isa_state_t  istate;
	isa_req_t    slot;
	logic        slot_valid;
	logic        slot_post;
	logic        slot_done;
	logic        launched;
	logic [31:0] rdata;
	logic [3:0]  rem;
	logic [4:0]  tcnt;
	logic        cs16_q;
	logic [7:0]  isa_ctl;
	logic [7:0]  post_ctl;

	// ISA engine decode
	wire       tick     = bclk_s[1] ^ bclk_d;
	wire       rise     = bclk_s[1] & ~bclk_d;
	wire       rdy      = rdy_s[1];
	wire       cs16_now = ~cs16_s[1];
	wire [1:0] cur_b    = low_byte(rem);
	wire [1:0] hi_b     = {cur_b[1], 1'b1};
	wire       pair     = ~cur_b[0] & rem[hi_b];
	wire       two      = cs16_q & pair;
	// Lanes still owed once this piece ends; address stays put through recovery
	wire [3:0] rem_left = rem & ~(4'h1 << cur_b) & ~(two ? (4'h1 << hi_b) : 4'h0);
	wire       rom_rd   = slot.rom & ~slot.write;
	wire       first_mb = slot.addr[31:20] == 12'h000;
	wire       cmd_on   = istate == I_CMD;
	wire       isa_go   = slot_valid & ~launched & (istate == I_IDLE); // [R10]
	wire       rise_dly = isa_ctl[`BIT_CMD_RISE_DLY];
	wire [4:0] ws_rom   = isa_ctl[`BIT_ROM_WS] ? ROM_FAST_WS : `WS_ROM_DEF; // [R18]
	wire [4:0] ws_now   = rom_rd ? ws_rom : (cs16_now ? `WS_16BIT : `WS_8BIT);
	wire [4:0] ws_q     = rom_rd ? ws_rom : (cs16_q ? `WS_16BIT : `WS_8BIT);
	wire [4:0] fall_dly = isa_ctl[`BIT_CMD_FALL_DLY] ? (cs16_now ? 5'h02 : 5'h04) : 5'h00; // [R14]
	// ROM reads start at BALE fall; 16-bit cycles at BALE fall, 8-bit half a BCLK later, each plus the bit 7 delay
	wire [4:0] fall_tks = rom_rd ? 5'h00 : (cs16_now ? 5'h00 : 5'h01) + fall_dly; // [R13] [R17]
	wire       release_c = cmd_on & tick & (tcnt == 5'h00) & rdy; // [R15]

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			istate    <= I_IDLE;
			rem       <= 4'h0;
			tcnt      <= 5'h00;
			cs16_q    <= 1'b0;
			launched  <= 1'b0;
			slot_done <= 1'b0;
			rdata     <= 32'h00000000;
		end else begin
			if (!slot_valid) begin
				launched  <= 1'b0;
				slot_done <= 1'b0;
			end
			case (istate)
				I_IDLE: begin
					if (isa_go && rise) begin
						launched <= 1'b1;
						rem      <= slot.be; // [R16] [R19]
						tcnt     <= 5'h01;
						if (slot.be == 4'h0) begin
							slot_done <= 1'b1;
						end else begin
							istate <= I_ADDR;
						end
					end
				end
				I_ADDR: begin
					if (tick) begin
						tcnt <= tcnt - 5'h01;
						if (tcnt == 5'h00) begin
							cs16_q <= cs16_now; // [R12]
							if (fall_tks == 5'h00) begin
								istate <= I_CMD;
								tcnt   <= cmd_ticks(ws_now, rise_dly);
							end else begin
								istate <= I_DLY;
								tcnt   <= fall_tks - 5'h01;
							end
						end
					end
				end
				I_DLY: begin
					if (tick) begin
						tcnt <= tcnt - 5'h01;
						if (tcnt == 5'h00) begin
							istate <= I_CMD;
							tcnt   <= cmd_ticks(ws_q, rise_dly);
						end
					end
				end
				I_CMD: begin
					if (tick && tcnt != 5'h00) begin
						tcnt <= tcnt - 5'h01;
					end
					if (release_c) begin
						istate    <= I_REC;
						tcnt      <= 5'h01;
						if (two) begin
							rdata[{hi_b, 3'h0} +: 8] <= sd_s1[15:8];
						end
						// 8-bit cards return every byte on the low lane
						rdata[{cur_b, 3'h0} +: 8] <= (cs16_q & cur_b[0]) ? sd_s1[15:8] : sd_s1[7:0];
					end
				end
				I_REC: begin
					if (tick) begin
						tcnt <= tcnt - 5'h01;
						if (tcnt == 5'h00) begin
							tcnt <= 5'h01;
							rem  <= rem_left; // [R16]
							if (rem_left != 4'h0) begin
								istate <= I_ADDR;
							end else begin
								istate    <= I_IDLE;
								slot_done <= 1'b1;
							end
						end
					end
				end
				default: istate <= I_IDLE;
			endcase
		end
	end

	// ISA outputs
	assign o_sa      = {slot.addr[23:2], cur_b};  // [R19]
	assign o_sbhe_n  = ~(pair | cur_b[0]);         // [R19]
	assign o_bale    = istate == I_ADDR;
	assign o_memr_n  = ~(cmd_on & ~slot.write);
	assign o_memw_n  = ~(cmd_on & slot.write);
	assign o_smemr_n = ~(cmd_on & ~slot.write & first_mb); // [R11]
	assign o_smemw_n = ~(cmd_on & slot.write & first_mb);  // [R11]
	assign o_sd      = {byte_of(slot.data, hi_b), byte_of(slot.data, cur_b)};
	assign o_sd_oe   = slot.write & (istate != I_IDLE);

	// PCI target state
	logic [4:0]  cnt;
	logic        frame_d;
	logic [31:0] cur_addr;
	logic        cur_w;
	logic        irdy_seen;
	logic        cfg_wr_done;
	logic        oth_seen;
	logic        trdy_n;
	logic        stop_n;
	logic        devsel_n;
	logic        ctl_oe;
	logic        ad_oe;
	logic [31:0] ad_out;

	wire [3:0] cmd      = i_cbe_n;
	wire [3:0] be       = ~i_cbe_n;
	wire       irdy     = ~i_irdy_n;
	wire       xfer     = ~trdy_n & irdy;
	wire       c_rd     = (cmd == `CMD_MRD) | (cmd == `CMD_MRM) | (cmd == `CMD_MRL); // [R23]
	wire       c_wr     = (cmd == `CMD_MWR) | (cmd == `CMD_MWI);                     // [R23]
	wire       own_hit  = (i_ad & OWN_MASK) == OWN_BASE;
	wire       c_mem    = (c_rd | c_wr) & ~own_hit; // [R1] [R24]
	wire       c_cfg    = i_idsel & ((cmd == `CMD_CFGRD) | (cmd == `CMD_CFGWR));
	wire       start    = frame_d & ~i_frame_n & ((pstate == P_IDLE) | (pstate == P_TURN)); // [R25]
	wire       ending   = ((pstate == P_MEM) | (pstate == P_CFG)) & (~trdy_n | ~stop_n);
	wire       hit      = slot_valid & ~slot_post & (slot.addr == cur_addr) &
	                      (slot.write == cur_w) & (slot.be == be) &
	                      (~cur_w | (slot.data == i_ad)); // [R8]
	wire       post_ok  = irdy & cur_w & post_ctl[`BIT_POST_EN] & ~slot_valid; // [R9]
	wire       done_ok  = irdy & hit & slot_done;                              // [R8]
	wire       cap      = irdy & ~slot_valid & ~post_ok;                       // [R4]
	wire       retry    = (irdy & slot_valid & ~hit) | (cnt >= `LAT_INIT_CLKS - 5'd1); // [R2] [R5]
	wire [5:0] dw       = cur_addr[7:2];
	wire       isa_dw   = {dw, 2'h0} == (`OFF_ISA_CTL & 8'hfc);
	wire       post_dw  = {dw, 2'h0} == (`OFF_POST_CTL & 8'hfc);
	wire [1:0] isa_ln   = 2'(`OFF_ISA_CTL % 4);
	wire [1:0] post_ln  = 2'(`OFF_POST_CTL % 4);
	wire [31:0] cfg_rd  = (isa_dw ? {24'h000000, isa_ctl} << {isa_ln, 3'h0} : 32'h00000000) |
	                      (post_dw ? {24'h000000, post_ctl} << {post_ln, 3'h0} : 32'h00000000);
	wire        cfg_wr_go = cur_w & ~cfg_wr_done & irdy_seen &
	                        (cnt >= `CFG_TRDY_CLKS - 5'd1) & (`CFG_WR_IRDY_CLKS == 5'd2);
	wire isa_req_t new_req = '{addr: cur_addr, be: be, write: cur_w, data: i_ad,
	                           rom: (cur_addr & ROM_MASK) == ROM_BASE};

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			pstate      <= P_IDLE;
			cnt         <= 5'h00;
			frame_d     <= 1'b1;
			cur_addr    <= 32'h00000000;
			cur_w       <= 1'b0;
			irdy_seen   <= 1'b0;
			cfg_wr_done <= 1'b0;
			oth_seen    <= 1'b0;
			trdy_n      <= 1'b1;
			stop_n      <= 1'b1;
			devsel_n    <= 1'b1;
			ctl_oe      <= 1'b0;
			ad_oe       <= 1'b0;
			ad_out      <= 32'h00000000;
			slot        <= '0;
			slot_valid  <= 1'b0;
			slot_post   <= 1'b0;
			isa_ctl     <= `ISA_CTL_RST;
			post_ctl    <= `POST_CTL_RST;
		end else begin
			frame_d <= i_frame_n;
			if (cnt != 5'h1f) begin
				cnt <= cnt + 5'h01;
			end
			// Posted write retires on its own once ISA is done
			if (slot_post && slot_done) begin
				slot_valid <= 1'b0;
			end
			if (start) begin
				cur_addr    <= i_ad;
				cur_w       <= c_wr | (cmd == `CMD_CFGWR);
				cnt         <= 5'h01;
				irdy_seen   <= 1'b0;
				cfg_wr_done <= 1'b0;
				oth_seen    <= 1'b0;
				// A back-to-back start still releases the strobes, as the turnaround step does
				ctl_oe      <= 1'b0;
				pstate      <= c_cfg ? P_CFG : (c_mem ? P_DEC : P_IDLE);
			end else if (ending) begin
				if (!stop_n) begin
					trdy_n <= 1'b1;
					pstate <= P_HOLD;
				end else if (xfer) begin // [R21]
					trdy_n   <= 1'b1;
					devsel_n <= 1'b1;
					ad_oe    <= 1'b0;
					pstate   <= P_TURN;
				end
			end else begin
				case (pstate)
					P_IDLE: begin
					end
					P_TURN: begin
						// Drive the strobes high for one cycle before letting go
						ctl_oe <= 1'b0;
						pstate <= P_IDLE;
					end
					P_DEC: begin
						oth_seen <= oth_seen | ~i_devsel_n;
						if (oth_seen || !i_devsel_n) begin
							pstate <= P_IDLE;
						end else if (cnt == `SUB_DEVSEL_CLKS) begin // [R1]
							devsel_n <= 1'b0;
							ctl_oe   <= 1'b1;
							ad_oe    <= ~cur_w;
							pstate   <= P_MEM;
						end
					end
					P_MEM: begin
						if (post_ok || done_ok) begin
							trdy_n <= 1'b0;
							// Each further phase needs a fresh slow ISA cycle
							stop_n <= i_frame_n; // [R3] [R6]
							ad_out <= rdata;
							if (post_ok) begin
								slot       <= new_req; // [R9]
								slot_valid <= 1'b1;
								slot_post  <= 1'b1;
							end else begin
								slot_valid <= 1'b0;
							end
						end else begin
							if (cap) begin
								slot       <= new_req; // [R4] [R8]
								slot_valid <= 1'b1;
								slot_post  <= 1'b0;
							end
							if (retry) begin
								stop_n <= 1'b0; // [R5]
							end
						end
					end
					P_CFG: begin
						irdy_seen <= irdy_seen | irdy;
						if (cnt == `CFG_DEVSEL_CLKS) begin // [R20]
							devsel_n <= 1'b0;
							ctl_oe   <= 1'b1;
							ad_oe    <= ~cur_w;
						end
						if (!cur_w && cnt == `CFG_TRDY_CLKS) begin // [R21]
							trdy_n <= 1'b0;
							stop_n <= i_frame_n;
							ad_out <= cfg_rd;
						end
						if (cfg_wr_go) begin // [R22]
							cfg_wr_done <= 1'b1;
							if (isa_dw && be[isa_ln]) begin
								isa_ctl <= byte_of(i_ad, isa_ln);
							end
							if (post_dw && be[post_ln]) begin
								post_ctl <= byte_of(i_ad, post_ln);
							end
						end
						if (cfg_wr_done) begin // [R22]
							trdy_n <= 1'b0;
							stop_n <= i_frame_n;
						end
					end
					P_HOLD: begin
						if (i_frame_n) begin
							stop_n   <= 1'b1;
							devsel_n <= 1'b1;
							ad_oe    <= 1'b0;
							pstate   <= P_TURN;
						end
					end
					default: pstate <= P_IDLE;
				endcase
			end
		end
	end

	// PCI outputs
	assign o_ad       = ad_out;
	assign o_ad_oe    = ad_oe;
	assign o_trdy_n   = trdy_n;
	assign o_stop_n   = stop_n;
	assign o_devsel_n = devsel_n;
	assign o_ctl_oe   = ctl_oe;

endmodule : pci_isa_bridge

/* File: test/pci_isa_bridge_assertions.sv */
`timescale 1ns/10ps
module pci_isa_bridge_assertions (
	// PCI
	input wire logic        i_clk,
	input wire logic        i_nrst,
	input wire logic        i_frame_n,
	input wire logic        i_irdy_n,
	input wire logic        i_idsel,
	input wire logic        i_devsel_n,
	input wire logic [31:0] i_ad,
	input wire logic [3:0]  i_cbe_n,
	input wire logic        o_ad_oe,
	input wire logic        o_trdy_n,
	input wire logic        o_stop_n,
	input wire logic        o_devsel_n,
	input wire logic        o_ctl_oe,
	// ISA
	input wire logic [23:0] o_sa,
	input wire logic        o_sbhe_n,
	input wire logic        o_bale,
	input wire logic        o_memr_n,
	input wire logic        o_memw_n,
	input wire logic        o_smemr_n,
	input wire logic        o_smemw_n
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	wire cmd_on = !o_memr_n || !o_memw_n;

	property p_cfg_devsel;
		$fell(i_frame_n) && i_idsel && i_cbe_n[3:1] == 3'b101 |-> ##3 !o_devsel_n;
	endproperty
	a_cfg_devsel: assert property (p_cfg_devsel)
		else $error("config claim late");
	property p_cfg_read;
		$fell(i_frame_n) && i_idsel && i_cbe_n == 4'ha |-> ##5 !o_trdy_n && o_ad_oe;
	endproperty
	a_cfg_read: assert property (p_cfg_read)
		else $error("config read ready late");
	property p_trdy_once;
		!o_trdy_n && !i_irdy_n |=> o_trdy_n;
	endproperty
	a_trdy_once: assert property (p_trdy_once)
		else $error("ready held after transfer");
	property p_latency;
		$fell(i_frame_n) && !i_idsel && i_ad[31:16] != 16'hffff
			&& i_cbe_n inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf}
			##1 i_devsel_n [*3] |-> ##[1:13] !o_trdy_n || !o_stop_n;
	endproperty
	a_latency: assert property (p_latency)
		else $error("initial latency exceeded");
	property p_retry;
		$fell(o_stop_n) && o_trdy_n |-> !o_devsel_n && o_ctl_oe;
	endproperty
	a_retry: assert property (p_retry)
		else $error("retry without claim");
	property p_dac;
		$fell(i_frame_n) && i_cbe_n == 4'hd |=> !o_ctl_oe [*6];
	endproperty
	a_dac: assert property (p_dac)
		else $error("dual address cycle answered");
	property p_smem;
		!o_smemr_n || !o_smemw_n |-> o_sa[23:20] == 4'h0
			&& (o_smemr_n || !o_memr_n) && (o_smemw_n || !o_memw_n);
	endproperty
	a_smem: assert property (p_smem)
		else $error("low-megabyte command misused");
	property p_bale;
		o_bale |-> !cmd_on;
	endproperty
	a_bale: assert property (p_bale)
		else $error("command during address state");
	property p_lanes;
		cmd_on |-> !(o_sbhe_n && o_sa[0]);
	endproperty
	a_lanes: assert property (p_lanes)
		else $error("undefined byte lane code");
endmodule : pci_isa_bridge_assertions

bind pci_isa_bridge pci_isa_bridge_assertions u_check (
	.i_clk(i_clk), .i_nrst(i_nrst), .i_frame_n(i_frame_n), .i_irdy_n(i_irdy_n),
	.i_idsel(i_idsel), .i_devsel_n(i_devsel_n), .i_ad(i_ad), .i_cbe_n(i_cbe_n),
	.o_ad_oe(o_ad_oe), .o_trdy_n(o_trdy_n), .o_stop_n(o_stop_n),
	.o_devsel_n(o_devsel_n), .o_ctl_oe(o_ctl_oe), .o_sa(o_sa), .o_sbhe_n(o_sbhe_n),
	.o_bale(o_bale), .o_memr_n(o_memr_n), .o_memw_n(o_memw_n),
	.o_smemr_n(o_smemr_n), .o_smemw_n(o_smemw_n));

/* File: test/isa_mem_model.sv */
`timescale 1ns/10ps
module isa_mem_model (
	// Slot bus
	input  wire logic        i_bclk,
	input  wire logic        i_memr_n,
	input  wire logic        i_memw_n,
	input  wire logic [23:0] i_sa,
	input  wire logic        i_sbhe_n,
	input  wire logic [15:0] i_sd,
	input  wire logic        i_sd_oe,
	// Card setup
	input  wire logic        i_wide,
	input  wire logic        i_slow,
	output logic             o_memcs16_n,
	output logic             o_iochrdy,
	output logic      [15:0] o_sd
);
	logic [7:0] mem [256];
	logic [3:0] hold = 4'h0;
	wire  [7:0] lo = {i_sa[7:1], 1'b0};

	initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
	// Pulled-up data lines when not read
	// Narrow cards answer every byte on the low lane
	assign o_sd = i_memr_n ? 16'hffff :
		i_wide ? {mem[lo | 8'h01], mem[lo]} : {8'hff, mem[i_sa[7:0]]};
	assign o_memcs16_n = !i_wide;
	assign o_iochrdy = (i_memr_n && i_memw_n) || hold == 4'h0;
	// Early low, so the stretch outlasts the normal wait states
	always @(posedge i_bclk)
		if (i_memr_n && i_memw_n) hold <= i_slow ? 4'h8 : 4'h0;
		else if (hold != 4'h0) hold <= hold - 4'h1;
	always @(posedge i_memw_n) if (i_sd_oe) begin
		if (!i_wide) mem[i_sa[7:0]] <= i_sd[7:0];
		else begin
			if (!i_sa[0]) mem[lo] <= i_sd[7:0];
			if (!i_sbhe_n) mem[lo | 8'h01] <= i_sd[15:8];
		end
	end
endmodule : isa_mem_model

/* File: test/pci_isa_bridge_bench.sv */
`timescale 1ns/10ps
`include "pci_isa_consts.svh"
module pci_isa_bridge_bench;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        bclk = 1'b0;
	logic        frame_n = 1'b1;
	logic        irdy_n = 1'b1;
	logic        idsel = 1'b0;
	logic        other_n = 1'b1;
	logic [31:0] ad = 32'h0;
	logic [3:0]  cbe_n = 4'h0;
	logic        wide = 1'b0;
	logic        slow = 1'b0;
	logic [31:0] seed = 32'hd57669aa;
	logic [7:0]  img [256];
	wire  [31:0] rd_ad;
	wire  [23:0] sa;
	wire  [15:0] sd_in, sd_out;
	wire         trdy_n, stop_n, rdy, cs16_n, memr_n, memw_n, sbhe_n, sd_oe;
	int          err_count = 0;
	int          comparisons = 0;
	int          run = 0;
	int          longest = 0;

	always #20 clk = ~clk;
	initial begin
		#7;
		forever #160 bclk = ~bclk;
	end
	always @(posedge clk) begin
		run <= memr_n ? 0 : run + 1;
		if (run > longest) longest <= run;
	end

	pci_isa_bridge DUT (.i_clk(clk), .i_nrst(nrst), .i_frame_n(frame_n), .i_irdy_n(irdy_n),
		.i_idsel(idsel), .i_devsel_n(other_n), .i_ad(ad), .i_cbe_n(cbe_n), .o_ad(rd_ad),
		.o_ad_oe(), .o_trdy_n(trdy_n), .o_stop_n(stop_n), .o_devsel_n(), .o_ctl_oe(),
		.i_bclk(bclk), .i_iochrdy(rdy), .i_memcs16_n(cs16_n), .i_sd(sd_in), .o_sa(sa),
		.o_sbhe_n(sbhe_n), .o_bale(), .o_memr_n(memr_n), .o_memw_n(memw_n), .o_smemr_n(),
		.o_smemw_n(), .o_sd(sd_out), .o_sd_oe(sd_oe));
	isa_mem_model u_card (.i_bclk(bclk), .i_memr_n(memr_n), .i_memw_n(memw_n), .i_sa(sa),
		.i_sbhe_n(sbhe_n), .i_sd(sd_out), .i_sd_oe(sd_oe), .i_wide(wide), .i_slow(slow),
		.o_memcs16_n(cs16_n), .o_iochrdy(rdy), .o_sd(sd_in));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] lanes(input logic [3:0] be);
		return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : lanes
	function automatic logic [31:0] image(input logic [7:0] a);
		return {img[a + 8'd3], img[a + 8'd2], img[a + 8'd1], img[a]};
	endfunction : image
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_of_test;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	// One single-phase transaction: res 0 unclaimed, 1 done, 2 retried
	task automatic pci(input logic [3:0] cmd, input logic [31:0] a, input logic [3:0] be,
		input logic [31:0] wd, output logic [31:0] rd, output int res);
		res = 0;
		@(posedge clk);
		frame_n <= 1'b0;
		ad <= a;
		cbe_n <= cmd;
		idsel <= cmd[3:1] == 3'b101;
		@(posedge clk);
		frame_n <= 1'b1;
		irdy_n <= 1'b0;
		cbe_n <= ~be;
		ad <= wd;
		idsel <= 1'b0;
		for (int i = 0; i < 24 && res == 0; i++) begin
			@(negedge clk);
			res = trdy_n === 1'b0 ? 1 : stop_n === 1'b0 ? 2 : 0;
		end
		rd = rd_ad;
		@(posedge clk);
		irdy_n <= 1'b1;
		@(posedge clk);
	endtask : pci
	task automatic mem(input logic [3:0] cmd, input logic [31:0] a, input logic [3:0] be,
		input logic [31:0] wd, output logic [31:0] rd);
		int res;
		res = 2;
		for (int n = 0; n < 400 && res != 1; n++) pci(cmd, a, be, wd, rd, res);
		if (res != 1) begin
			err_count++;
			end_of_test();
		end
	endtask : mem
	task automatic setup(input logic [7:0] ctl, input logic post);
		logic [31:0] rd;
		int          res;
		pci(`CMD_CFGWR, 32'h40, 4'h1, {24'h0, ctl}, rd, res);
		pci(`CMD_CFGWR, 32'h44, 4'h4, {15'h0, post, 16'h0}, rd, res);
	endtask : setup

	initial begin
		logic [31:0] rd;
		logic [31:0] a;
		logic [31:0] wd;
		logic [3:0]  be;
		logic        post;
		int          res;
		for (int i = 0; i < 256; i++) img[i] = 8'(i) ^ 8'h5a;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			a = 32'h40 + 32'(k * 4);
			pci(`CMD_CFGRD, a, 4'hf, 0, rd, res);
			check("cfg reset", rd, 0);
			seed = lfsr(seed);
			wd = {4{seed[7:0]}};
			pci(`CMD_CFGWR, a, 4'hf, wd, rd, res);
			pci(`CMD_CFGRD, a, 4'hf, 0, rd, res);
			check("cfg data", rd, k == 2 ? 0 : wd & (k == 0 ? 32'hff : 32'hff0000));
		end
		for (int k = 0; k < 12; k++) begin
			seed = lfsr(seed);
			post = seed[8];
			setup(seed[7:0] & 8'ha2, post);
			wide <= seed[9];
			a = {11'h0, seed[20], 12'h0, seed[31:26], 2'b00};
			be = seed[13:10];
			seed = lfsr(seed);
			wd = seed;
			if (post) begin
				pci(k[0] ? `CMD_MWI : `CMD_MWR, a, be, wd, rd, res);
				check("posted", res, 1);
			end else
				mem(k[0] ? `CMD_MWI : `CMD_MWR, a, be, wd, rd);
			for (int i = 0; i < 4; i++) if (be[i]) img[a[7:0] + 8'(i)] = wd[8 * i +: 8];
			be = seed[31:28];
			mem(k % 3 == 0 ? `CMD_MRD : k % 3 == 1 ? `CMD_MRM : `CMD_MRL, a, be, 0, rd);
			check("read", rd & lanes(be), image(a[7:0]) & lanes(be));
		end
		for (int k = 0; k < 2; k++) begin
			setup(k ? 8'h02 : 8'h00, 1'b0);
			mem(`CMD_MRD, 32'h000e0040, 4'hf, 0, rd);
			check("rom", rd, image(8'h40));
		end
		slow <= 1'b1;
		wide <= 1'b0;
		mem(`CMD_MRD, 32'h10, 4'h3, 0, rd);
		slow <= 1'b0;
		check("slow data", rd & 32'hffff, image(8'h10) & 32'hffff);
		// Unstretched commands stay near 48 clocks at most
		check("slow stretch", longest >= 56, 1);
		for (int k = 0; k < 3; k++) begin
			other_n <= k != 2;
			pci(k == 1 ? 4'hd : `CMD_MRD, k == 0 ? 32'hffff0040 : 32'h40, 4'hf, 0, rd, res);
			check("unclaimed", res, 0);
		end
		other_n <= 1'b1;
		end_of_test();
	end
endmodule : pci_isa_bridge_bench
